// file: hdl/flash_pkg.sv
/*
  Shared constants for the serial flash write, erase and protection logic:
  command codes, status bit layout, array geometry and operation times.
  Assumes a 250 MHz system clock; the serial clock comes from the host.
*/
`default_nettype none

package flash_pkg;

  // ---------------------------------------------------------------------
  // Command codes, most significant bit first on the serial input
  // ---------------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_FULL_CLEAR = 8'hC7;
  localparam logic [7:0] OP_SECTOR_CLEAR = 8'hD8;

  // ---------------------------------------------------------------------
  // Status register layout
  // ---------------------------------------------------------------------
  localparam int BIT_BUSY = 0;
  localparam int BIT_UNLOCK = 1;
  localparam int BIT_GUARD_LO = 2;
  localparam int BIT_GUARD_HI = 4;
  localparam int BIT_LOCK = 7;
  localparam logic [2:0] GUARD_NONE = 3'h0;
  localparam logic [2:0] GUARD_ALL = 3'h6;

  // ---------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_MSB = 20;
  localparam logic [5:0] NUM_SECTORS = 6'h20;

  // ---------------------------------------------------------------------
  // Operation times and their cycle counts (rounded up)
  // ---------------------------------------------------------------------
  localparam longint unsigned CLK_MHZ = 250;
  localparam longint unsigned T_W_NS = 100;
  localparam longint unsigned T_PP_US = 1500;
  localparam longint unsigned T_SE_MS = 1000;
  localparam longint unsigned T_BE_MS = 16000;
  localparam logic [31:0] W_CYC = 32'((T_W_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] PP_CYC = 32'(T_PP_US * CLK_MHZ);
  localparam logic [31:0] SE_CYC = 32'(T_SE_MS * CLK_MHZ * 1000);
  localparam logic [31:0] BE_CYC = 32'(T_BE_MS * CLK_MHZ * 1000);

  typedef enum {ST_IDLE, ST_UPDATE, ST_PROG, ST_WAIT} op_state_t;

endpackage

`default_nettype wire

// file: hdl/spi_link_if.sv
/*
  Carries received serial bytes from the serial clock domain to the core.
  Assumes the byte word is stable for many system clocks after each toggle.
*/
`default_nettype none

interface spi_link_if;
  logic [7:0] byte_data;
  logic byte_tgl;
  logic partial;
  modport link (output byte_data, output byte_tgl, output partial);
  modport core (input byte_data, input byte_tgl, input partial);
endinterface

`default_nettype wire

// file: hdl/spi_link_rx.sv
/*
  Serial input shifter on the host's serial clock. Assembles bytes, flags
  each completed byte by a toggle and reports an unfinished byte as a level.
  Assumes the serial clock runs only while chip select is low.
*/
`default_nettype none

module spi_link_rx
  import flash_pkg::*;
(
  input wire logic i_sck,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_si,
  spi_link_if.link lnk
);

  logic frame_idle;
  logic first;
  logic [2:0] bit_cnt;
  logic [2:0] cur_bit;
  logic [6:0] shreg;
  logic [7:0] byte_data;
  logic byte_tgl;

  assign frame_idle = i_cs_n | i_rst;
  assign cur_bit = first ? 3'h0 : bit_cnt;

  // --------------------------------------------------------------------
  // First edge of a frame restarts the bit count
  // --------------------------------------------------------------------
  always_ff @(posedge i_sck or posedge frame_idle)
  begin
    if (frame_idle)
      first <= 1'b1;
    else
      first <= 1'b0;
  end

  always_ff @(posedge i_sck or posedge i_rst)
  begin
    if (i_rst)
      bit_cnt <= 3'h0;
    else
      bit_cnt <= cur_bit + 3'h1;
  end

  always_ff @(posedge i_sck or posedge i_rst)
  begin
    if (i_rst)
      shreg <= 7'h00;
    else
      shreg <= {shreg[5:0], i_si};
  end

  always_ff @(posedge i_sck or posedge i_rst)
  begin
    if (i_rst)
    begin
      byte_data <= 8'h00;
      byte_tgl <= 1'b0;
    end
    else if (cur_bit == 3'h7)
    begin
      byte_data <= {shreg, i_si};
      byte_tgl <= ~byte_tgl;
    end
  end

  assign lnk.byte_data = byte_data;
  assign lnk.byte_tgl = byte_tgl;
  assign lnk.partial = (bit_cnt != 3'h0);

endmodule

`default_nettype wire

// file: hdl/flash_write_ctrl.sv
/*
  Write side of a serial flash: status write, protection modes, page
  program, sector erase and bulk erase, sequenced on the system clock.
  Assumes an array macro that ANDs each written byte into its cell and
  performs erase on a one-cycle request; the host drives the serial pins.
*/
`default_nettype none

module flash_write_ctrl
  import flash_pkg::*;
#(
  parameter logic [31:0] PP_CYCLES = PP_CYC,
  parameter logic [31:0] SE_CYCLES = SE_CYC,
  parameter logic [31:0] BE_CYCLES = BE_CYC
)
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_SI,
  input wire logic I_WP_N,
  output logic [7:0] O_STATUS,
  output logic O_PIN_LOCKED_MODE,
  output logic O_ARR_WE,
  output logic [ADDR_W-1:0] O_ARR_ADDR,
  output logic [7:0] O_ARR_DATA,
  output logic O_ARR_SECTOR_CLEAR,
  output logic O_ARR_FULL_CLEAR
);

  spi_link_if lnk ();

  spi_link_rx u_rx (
    .i_sck(I_SCK),
    .i_rst(I_SYS_RST),
    .i_cs_n(I_CS_N),
    .i_si(I_SI),
    .lnk(lnk)
  );

  // --------------------------------------------------------------------
  // Crossings into the system clock
  // --------------------------------------------------------------------
  logic [3:0] cs_s;
  logic [2:0] tg_s;
  logic [1:0] part_s;
  logic [1:0] wp_s;

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      cs_s <= 4'hF;
      tg_s <= 3'h0;
      part_s <= 2'h0;
      wp_s <= 2'h3;
    end
    else
    begin
      cs_s <= {cs_s[2:0], I_CS_N};
      tg_s <= {tg_s[1:0], lnk.byte_tgl};
      part_s <= {part_s[0], lnk.partial};
      wp_s <= {wp_s[0], I_WP_N};
    end
  end

  // Select edge is seen one stage after the byte toggle, so the last byte
  // of a frame is always counted before the frame is judged
  logic byte_ev;
  logic frame_end;
  assign byte_ev = tg_s[2] ^ tg_s[1];
  assign frame_end = cs_s[2] & ~cs_s[3];

  // --------------------------------------------------------------------
  // Status register and protection
  // --------------------------------------------------------------------
  op_state_t state;
  logic busy;
  logic lock;
  logic [2:0] guard;
  logic write_unlock_latch;
  logic pin_locked;

  assign busy = (state != ST_IDLE);
  assign pin_locked = ~wp_s[1] & lock;
  assign O_STATUS = {lock, 2'b00, guard, write_unlock_latch, busy};
  assign O_PIN_LOCKED_MODE = pin_locked;

  function automatic logic guarded(input logic [4:0] sec,
                                   input logic [2:0] bp);
    logic [5:0] size;
    begin
      if (bp == GUARD_NONE)
        size = 6'h00;
      else if (bp >= GUARD_ALL)
        size = NUM_SECTORS;
      else
        size = 6'h01 << (bp - 3'h1);
      guarded = ({1'b0, sec} >= (NUM_SECTORS - size));
    end
  endfunction

  // --------------------------------------------------------------------
  // Frame decode
  // --------------------------------------------------------------------
  logic [7:0] opcode;
  logic [2:0] idx;
  logic dead;
  logic extra;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wr_data;
  logic [7:0] data_cnt;
  logic over;

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      opcode <= 8'h00;
      idx <= 3'h0;
      dead <= 1'b0;
      extra <= 1'b0;
      addr <= 24'h00_0000;
      wr_data <= 8'h00;
      data_cnt <= 8'h00;
      over <= 1'b0;
    end
    else if (frame_end)
    begin
      idx <= 3'h0;
      extra <= 1'b0;
      data_cnt <= 8'h00;
      over <= 1'b0;
    end
    else if (byte_ev)
    begin
      if (idx == 3'h0)
      begin
        opcode <= lnk.byte_data;
        dead <= busy;
      end
      else if (idx != 3'h4)
        addr <= {addr[15:0], lnk.byte_data};
      if (idx == 3'h1)
        wr_data <= lnk.byte_data;
      if (idx == 3'h4)
      begin
        extra <= 1'b1;
        data_cnt <= data_cnt + 8'h01;
        if (extra && data_cnt == 8'h00)
          over <= 1'b1;
      end
      else
        idx <= idx + 3'h1;
    end
  end

  // --------------------------------------------------------------------
  // Page buffer
  // --------------------------------------------------------------------
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid;
  logic buf_wr;
  logic [7:0] buf_idx;

  assign buf_wr = byte_ev & ~frame_end & (idx == 3'h4) & ~dead &
                  (opcode == OP_PAGE_WRITE);
  assign buf_idx = addr[7:0] + data_cnt;

  always_ff @(posedge I_CLK)
  begin
    if (buf_wr)
      page_buf[buf_idx] <= lnk.byte_data;
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      page_valid <= '0;
    else if (byte_ev & ~frame_end & (idx == 3'h0) & ~busy)
      page_valid <= '0;
    else if (buf_wr)
      page_valid[buf_idx] <= 1'b1;
  end

  // --------------------------------------------------------------------
  // Command acceptance at the end of a frame
  // --------------------------------------------------------------------
  logic judge;
  logic go_status_write_cmd;
  logic go_pp;
  logic go_se;
  logic go_be;
  logic [4:0] sector;

  assign sector = addr[SECTOR_MSB:SECTOR_LSB];
  assign judge = frame_end & ~part_s[1] & ~busy & ~dead & write_unlock_latch;
  assign go_status_write_cmd = judge & (opcode == OP_STATUS_WRITE) & (idx == 3'h2) &
                   ~pin_locked;
  assign go_pp = judge & (opcode == OP_PAGE_WRITE) & extra &
                 ~guarded(sector, guard);
  assign go_se = judge & (opcode == OP_SECTOR_CLEAR) & (idx == 3'h4) &
                 ~extra & ~guarded(sector, guard);
  assign go_be = judge & (opcode == OP_FULL_CLEAR) & (idx == 3'h1) &
                 (guard == GUARD_NONE);

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      write_unlock_latch <= 1'b0;
    else if (go_status_write_cmd | go_pp | go_se | go_be)
      write_unlock_latch <= 1'b0;
    else if (frame_end & ~part_s[1] & ~busy & ~dead & (idx == 3'h1) &
             (opcode == OP_WRITE_UNLOCK))
      write_unlock_latch <= 1'b1;
    else if (frame_end & ~part_s[1] & ~busy & ~dead & (idx == 3'h1) &
             (opcode == OP_WRITE_LOCK))
      write_unlock_latch <= 1'b0;
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      lock <= 1'b0;
      guard <= GUARD_NONE;
    end
    else if (go_status_write_cmd)
    begin
      lock <= wr_data[BIT_LOCK];
      guard <= wr_data[BIT_GUARD_HI:BIT_GUARD_LO];
    end
  end

  // --------------------------------------------------------------------
  // Self-timed operation sequencer
  // --------------------------------------------------------------------
  logic [31:0] timer;
  logic [8:0] emit;
  logic [7:0] rd_base;
  logic [15:0] page;
  logic [7:0] rd_idx;

  assign rd_idx = rd_base + emit[7:0];

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state <= ST_IDLE;
      timer <= 32'h0000_0000;
      emit <= 9'h000;
      rd_base <= 8'h00;
      page <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          emit <= 9'h000;
          page <= addr[ADDR_W-1:8];
          rd_base <= over ? buf_idx : 8'h00;
          if (go_status_write_cmd)
          begin
            state <= ST_UPDATE;
            timer <= W_CYC;
          end
          else if (go_pp)
          begin
            state <= ST_PROG;
            timer <= PP_CYCLES;
          end
          else if (go_se | go_be)
          begin
            state <= ST_WAIT;
            timer <= go_se ? SE_CYCLES : BE_CYCLES;
          end
        end
        ST_PROG:
        begin
          timer <= timer - 32'h0000_0001;
          emit <= emit + 9'h001;
          if (emit == 9'(PAGE_BYTES - 1))
            state <= ST_WAIT;
        end
        ST_UPDATE, ST_WAIT:
        begin
          timer <= timer - 32'h0000_0001;
          if (timer <= 32'h0000_0001)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Array requests
  // --------------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_ARR_WE <= 1'b0;
      O_ARR_ADDR <= 24'h00_0000;
      O_ARR_DATA <= 8'h00;
      O_ARR_SECTOR_CLEAR <= 1'b0;
      O_ARR_FULL_CLEAR <= 1'b0;
    end
    else
    begin
      O_ARR_SECTOR_CLEAR <= go_se;
      O_ARR_FULL_CLEAR <= go_be;
      O_ARR_WE <= (state == ST_PROG) & page_valid[rd_idx];
      O_ARR_DATA <= page_buf[rd_idx];
      if (state == ST_PROG)
        O_ARR_ADDR <= {page, emit[7:0]};
      else if (go_se | go_be)
        O_ARR_ADDR <= addr;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  reserved_zero_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST) O_STATUS[6:5] == 2'b00)
    else $error("reserved status bits not zero");

  unlock_gate_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(busy) |-> $past(write_unlock_latch))
    else $error("operation started without unlock latch");

  unlock_source_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(write_unlock_latch) |-> $past(frame_end) && $past(opcode) == OP_WRITE_UNLOCK)
    else $error("unlock latch set by something else");

  unlock_clear_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(busy) |-> !write_unlock_latch ##1 !write_unlock_latch)
    else $error("unlock latch still set in operation");

  pin_lock_hold_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (pin_locked && frame_end) |=> $stable(O_STATUS[7:2]))
    else $error("status changed while pin locked");

  pin_lock_exit_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    $fell(pin_locked) |-> wp_s[1])
    else $error("pin lock left while pin low");

  misaligned_end_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (frame_end && part_s[1] && !busy) |=> !busy)
    else $error("operation started on misaligned frame");

  prog_page_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    O_ARR_WE |-> (O_ARR_ADDR[ADDR_W-1:8] == page))
    else $error("program left its page");

  prog_guard_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (state == ST_PROG) |-> !guarded(page[12:8], guard))
    else $error("program into guarded page");

  bulk_guard_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    O_ARR_FULL_CLEAR |-> (guard == GUARD_NONE) && busy)
    else $error("bulk erase with guard bits set");

endmodule

`default_nettype wire

// file: verification/host_spi_model.sv
/*
  Host-side serial model: drives select, serial clock and serial data.
  Assumes the bench calls frame() one frame at a time and leaves gaps.
*/
`default_nettype none

module host_spi_model
(
  output var logic o_cs_n,
  output var logic o_sck,
  output var logic o_si
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 40;

  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end

  // ---------------------------------------------------------------
  // Whole bytes, then extra_bits of one more byte to end off-boundary
  // ---------------------------------------------------------------
  task automatic frame(input logic [7:0] q[$], input int extra_bits);
    logic [7:0] b;
    o_cs_n = 1'b0;
    for (int n = 0; n <= q.size(); n++)
    begin
      b = (n < q.size()) ? q[n] : 8'ha5;
      for (int i = 7; i >= 0; i--)
      begin
        if (n == q.size() && 7 - i >= extra_bits)
          break;
        o_si = b[i];
        #HALF o_sck = 1'b1;
        #HALF o_sck = 1'b0;
      end
    end
    #HALF o_cs_n = 1'b1;
    // Released data line shows the inverse, never a stale value
    o_si = ~o_si;
    #HALF;
  endtask
endmodule

`default_nettype wire

// file: verification/tb.sv
/*
  Self-checking bench for the flash write, erase and protection block.
  Assumes shortened operation counts and a host model on the serial pins.
*/
`default_nettype none

module tb;
  import flash_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] PP_N = 32'h0000_0190;
  localparam logic [31:0] SE_N = 32'h0000_0032;
  localparam logic [31:0] BE_N = 32'h0000_003c;

  logic clk, rst, wp_n, cs_n, sck, si;
  logic [7:0] status;
  logic locked, we, sc, fc;
  logic [23:0] addr, first_addr, last_addr, sc_addr;
  logic [7:0] data, first_data, last_data;
  logic [7:0] q[$];
  int failures, n_compared, we_cnt, sc_cnt, fc_cnt;
  logic busy_seen;

  flash_write_ctrl #(.PP_CYCLES(PP_N), .SE_CYCLES(SE_N), .BE_CYCLES(BE_N))
    flash_write_ctrl_i (.I_CLK(clk), .I_SYS_RST(rst), .I_SCK(sck),
    .I_CS_N(cs_n), .I_SI(si), .I_WP_N(wp_n), .O_STATUS(status),
    .O_PIN_LOCKED_MODE(locked), .O_ARR_WE(we), .O_ARR_ADDR(addr),
    .O_ARR_DATA(data), .O_ARR_SECTOR_CLEAR(sc), .O_ARR_FULL_CLEAR(fc));

  host_spi_model host_spi_model_i (.o_cs_n(cs_n), .o_sck(sck), .o_si(si));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Array-side monitor
  // ---------------------------------------------------------------
  always @(negedge clk)
  begin
    if (status[BIT_BUSY] === 1'b1)
      busy_seen <= 1'b1;
    if (we === 1'b1)
    begin
      if (we_cnt == 0)
      begin
        first_addr <= addr;
        first_data <= data;
      end
      last_addr <= addr;
      last_data <= data;
      we_cnt <= we_cnt + 1;
    end
    if (sc === 1'b1)
    begin
      sc_addr <= addr;
      sc_cnt <= sc_cnt + 1;
    end
    if (fc === 1'b1)
      fc_cnt <= fc_cnt + 1;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Sends a frame, then waits for any started operation to finish
  task automatic send(input logic [7:0] f[$], input int extra);
    int n;
    @(posedge clk);
    #1;
    we_cnt = 0;
    sc_cnt = 0;
    fc_cnt = 0;
    busy_seen = 1'b0;
    host_spi_model_i.frame(f, extra);
    n = 0;
    repeat (8) @(posedge clk);
    while (status[BIT_BUSY] !== 1'b0 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000)
      check("busy wait", 32'(status[BIT_BUSY]), 32'h0000_0000);
    #1;
  endtask

  // Unlock first, then the command itself
  task automatic op(input logic [7:0] f[$], input int extra);
    send('{OP_WRITE_UNLOCK}, 0);
    send(f, extra);
  endtask

  initial
  begin
    #400_000;
    failures++;
    $display("[FAIL] watchdog expected finish seen hang");
    stop_test();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    wp_n = 1'b1;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    check("reset status", status, 8'h00);
    send('{OP_STATUS_WRITE, 8'he5}, 0);
    check("write no unlock", status, 8'h00);
    send('{OP_WRITE_UNLOCK}, 0);
    check("unlock", status, 8'h02);
    send('{OP_WRITE_LOCK}, 0);
    check("relock", status, 8'h00);
    send('{OP_WRITE_UNLOCK}, 0);
    send('{OP_STATUS_WRITE, 8'he5}, 0);
    check("status busy", busy_seen, 1'b1);
    check("status write", status, 8'h84);
    $display("test status_write done");
    @(posedge clk);
    #1 wp_n = 1'b0;
    repeat (6) @(posedge clk);
    check("pin locked", locked, 1'b1);
    op('{OP_STATUS_WRITE, 8'h00}, 0);
    check("locked write", status, 8'h86);
    send('{OP_PAGE_WRITE, 8'h1f, 8'h00, 8'h00, 8'h11}, 0);
    check("guarded prog", we_cnt, 0);
    check("guarded busy", busy_seen, 1'b0);
    send('{OP_SECTOR_CLEAR, 8'h1f, 8'h12, 8'h34}, 0);
    check("guarded sector", sc_cnt, 0);
    send('{OP_FULL_CLEAR}, 0);
    check("guarded bulk", fc_cnt, 0);
    $display("test protection done");
    send('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h10, 8'h3c, 8'hf0, 8'h0f}, 0);
    check("prog count", we_cnt, 3);
    check("prog addr0", first_addr, 24'h00_0010);
    check("prog data0", first_data, 8'h3c);
    check("prog addr2", last_addr, 24'h00_0012);
    check("prog data2", last_data, 8'h0f);
    check("prog busy", busy_seen, 1'b1);
    check("prog latch", status, 8'h84);
    send('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h20, 8'h55}, 0);
    check("prog no latch", we_cnt, 0);
    op('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h30, 8'haa}, 4);
    check("prog cut", we_cnt, 0);
    q = '{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h05};
    for (int k = 0; k < 258; k++)
      q.push_back(8'(k));
    send('{OP_WRITE_UNLOCK}, 0);
    send(q, 0);
    check("wrap count", we_cnt, 256);
    check("wrap addr0", first_addr, 24'h00_0000);
    check("wrap data0", first_data, 8'h02);
    check("wrap addr255", last_addr, 24'h00_00ff);
    check("wrap data255", last_data, 8'h01);
    $display("test program done");
    op('{OP_SECTOR_CLEAR, 8'h02, 8'h00, 8'h00}, 3);
    check("sector cut", sc_cnt, 0);
    send('{OP_SECTOR_CLEAR, 8'h03, 8'hab, 8'hcd}, 0);
    check("sector count", sc_cnt, 1);
    check("sector addr", sc_addr, 24'h03_abcd);
    check("sector latch", status, 8'h84);
    $display("test sector done");
    @(posedge clk);
    #1 wp_n = 1'b1;
    repeat (6) @(posedge clk);
    check("pin unlocked", locked, 1'b0);
    op('{OP_STATUS_WRITE, 8'h18}, 0);
    check("soft write", status, 8'h18);
    op('{OP_SECTOR_CLEAR, 8'h00, 8'h00, 8'h00}, 0);
    check("all guarded", sc_cnt, 0);
    check("all guarded latch", status, 8'h1a);
    op('{OP_STATUS_WRITE}, 5);
    check("short write", status, 8'h1a);
    send('{OP_STATUS_WRITE, 8'h00}, 0);
    check("soft clear", status, 8'h00);
    op('{OP_FULL_CLEAR}, 0);
    check("bulk count", fc_cnt, 1);
    check("bulk latch", status, 8'h00);
    $display("test bulk done");
    stop_test();
  end
endmodule

`default_nettype wire
